// ---- src/loop_code_pkg.sv ----
// shared constants and carrier types of the loop-code and fifo-limit status block
package loop_code_pkg;

  // register map, byte addresses on the axi4-lite slave
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'hc;

  // field positions: fifo-limit and loop-code shared by status, irq status and irq mask, mode bits in control
  localparam int BIT_FIFO_LIMIT = 5;
  localparam int BIT_UNUSED = 4;
  localparam int BIT_LOOP_CODE = 3;
  localparam int BIT_REMOTE_LOOP = 2;
  localparam int BIT_MODE_HI = 1;
  localparam int BIT_MODE_LO = 0;
  localparam logic [7:0] IRQ_BITS_MASK = 8'h28;
  localparam logic [7:0] CONTROL_MASK = 8'h03;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // loop-detect mode codes {hi, lo}
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_MAN_UP = 2'h1;
  localparam logic [1:0] MODE_MAN_DOWN = 2'h2;
  localparam logic [1:0] MODE_AUTO = 2'h3;

  // loop codes, oldest bit in the msb
  localparam int UP_LEN = 5;
  localparam int DOWN_LEN = 3;
  localparam logic [UP_LEN-1:0] PAT_UP = 5'h01;
  localparam logic [DOWN_LEN-1:0] PAT_DOWN = 3'h1;

  // timing
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned HOLD_TIME_S = 5;
  localparam int unsigned HOLD_CYCLES_DEF = HOLD_TIME_S * CLK_HZ;
  localparam int CNT_W = 32;

  // jitter attenuator fifo pointers
  localparam int JA_PTR_W = 5;
  localparam logic [JA_PTR_W-1:0] JA_NEAR_LIMIT = 5'h03;

  typedef struct packed {
    logic [JA_PTR_W-1:0] wr;
    logic [JA_PTR_W-1:0] rd;
  } ja_ptr_s;

  typedef enum logic [4:0] {
    ST_OFF = 5'h01,
    ST_MAN_UP = 5'h02,
    ST_MAN_DOWN = 5'h04,
    ST_AUTO_WAIT = 5'h08,
    ST_AUTO_LOOP = 5'h10
  } loop_state_e;

endpackage : loop_code_pkg

// ---- src/loop_pattern_watch.sv ----
// watches the received bit stream for a repeating loop code and times how long it lasts
`timescale 1ns/10ps
`default_nettype none
module loop_pattern_watch
  import loop_code_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = HOLD_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic bit_en,
  input wire logic bit_val,
  input wire logic want_down,
  input wire logic restart,
  output logic present,
  output logic held
);

  // a window of one code length cannot tell 00100 of the loop-up stream from the loop-down stream,
  // so both codes are judged over eight bits, where their ones are spaced apart differently
  localparam int WIN_LEN = UP_LEN + DOWN_LEN;
  localparam int UP_REP = 3;
  localparam int DOWN_REP = 4;
  logic [WIN_LEN-1:0] win_q;
  logic [CNT_W-1:0] cnt_q;
  logic [UP_LEN-1:0] up_hit;
  logic [DOWN_LEN-1:0] down_hit;
  logic match;
  // enough copies that every phase of the code has a whole window
  localparam logic [UP_REP*UP_LEN-1:0] UP_DUP = {UP_REP{PAT_UP}};
  localparam logic [DOWN_REP*DOWN_LEN-1:0] DOWN_DUP = {DOWN_REP{PAT_DOWN}};
  localparam logic [CNT_W-1:0] HOLD_LIM = HOLD_CYCLES[CNT_W-1:0];

  // the code repeats, so any phase of it in the window counts as a hit
  for (genvar i = 0; i < UP_LEN; i++) begin : g_up
    assign up_hit[i] = (win_q == UP_DUP[i +: WIN_LEN]);
  end
  for (genvar j = 0; j < DOWN_LEN; j++) begin : g_down
    assign down_hit[j] = (win_q == DOWN_DUP[j +: WIN_LEN]);
  end

  assign match = want_down ? |down_hit : |up_hit;
  assign present = match;
  // "longer than" the hold time: one cycle past the limit
  assign held = match && (cnt_q == HOLD_LIM);

  always_ff @(posedge clk) begin
    if (rst) begin
      win_q <= '0;
    end else if (bit_en) begin
      win_q <= {win_q[WIN_LEN-2:0], bit_val};
    end
  end

  // saturating timer, cleared whenever the code breaks or the watched code changes
  always_ff @(posedge clk) begin
    if (rst || restart || !match) begin
      cnt_q <= '0;
    end else if (cnt_q != HOLD_LIM) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

endmodule : loop_pattern_watch
`default_nettype wire

// ---- src/loop_code_status.sv ----
// loop-code detection and fifo-limit status of one receive channel, with axi4-lite registers
// Notes on behaviour
// - fifo-limit flag high while jitter fifo pointers are within three positions.
// - every rise and fall of the fifo-limit flag raises its interrupt when enabled.
// - the unused status bit between the two flags always reads zero.
// - manual loop-up mode sets loop flag after 00001 persists over five seconds.
// - manual loop-up flag follows the pattern, clears at once; transitions interrupt.
// - manual loop-down mode sets loop flag after 001 persists over five seconds.
// - manual loop-down flag follows the pattern, clears at once; transitions interrupt.
// - entering automatic mode clears the loop flag and watches for loop-up.
// - automatic: loop-up over five seconds sets flag, remote loop-back, watch loop-down.
// - automatic: flag stays high throughout remote loop-back, whatever the line sends.
// - loop-down code or leaving automatic mode ends remote loop-back, clearing the flag with interrupt.
//
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module loop_code_status
  import loop_code_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = HOLD_CYCLES_DEF
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic RX_DATA,
  input wire logic RX_STROBE,
  input wire loop_code_pkg::ja_ptr_s JA_PTRS,
  input wire logic [loop_code_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [loop_code_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic IRQ,
  output logic REMOTE_LOOPBACK
);
  import loop_code_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // line input synchroniser
  logic [1:0] rx_s1_q;
  logic [1:0] rx_s2_q;
  logic strobe_s3_q;
  logic bit_en;
  logic bit_val;

  always_ff @(posedge CLK) begin
    if (RST) begin
      rx_s1_q <= '0;
      rx_s2_q <= '0;
      strobe_s3_q <= 1'b0;
    end else begin
      rx_s1_q <= {RX_STROBE, RX_DATA};
      rx_s2_q <= rx_s1_q;
      strobe_s3_q <= rx_s2_q[1];
    end
  end

  // data and strobe travel through the same stages, so the data is stable at the edge
  assign bit_en = rx_s2_q[1] && !strobe_s3_q;
  assign bit_val = rx_s2_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // fifo limit
  logic [JA_PTR_W-1:0] ja_fwd;
  logic [JA_PTR_W-1:0] ja_back;
  logic fifo_flag_d;
  logic fifo_flag_q;

  assign ja_fwd = JA_PTRS.wr - JA_PTRS.rd;
  assign ja_back = JA_PTRS.rd - JA_PTRS.wr;
  assign fifo_flag_d = (ja_fwd <= JA_NEAR_LIMIT) || (ja_back <= JA_NEAR_LIMIT);

  always_ff @(posedge CLK) begin
    if (RST) begin
      fifo_flag_q <= 1'b0;
    end else begin
      fifo_flag_q <= fifo_flag_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // loop-code state machine
  logic [1:0] mode_q;
  loop_state_e state_q;
  loop_state_e state_d;
  loop_state_e mode_state;
  logic want_down;
  logic restart;
  logic pat_present;
  logic pat_held;
  logic loop_flag_d;
  logic loop_flag_q;
  logic remote_loop_d;
  logic remote_loop_q;

  assign mode_state = (mode_q == MODE_MAN_UP) ? ST_MAN_UP :
                      (mode_q == MODE_MAN_DOWN) ? ST_MAN_DOWN :
                      (mode_q == MODE_AUTO) ? ST_AUTO_WAIT : ST_OFF;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OFF, ST_MAN_UP, ST_MAN_DOWN: begin
        state_d = mode_state;
      end
      ST_AUTO_WAIT: begin
        if (mode_q != MODE_AUTO) begin
          state_d = mode_state;
        end else if (pat_held) begin
          state_d = ST_AUTO_LOOP;
        end
      end
      ST_AUTO_LOOP: begin
        if (mode_q != MODE_AUTO) begin
          state_d = mode_state;
        end else if (pat_present) begin
          state_d = ST_AUTO_WAIT;
        end
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
  end

  // only the auto loop and manual loop-down states watch for the loop-down code
  assign want_down = (state_q == ST_MAN_DOWN) || (state_q == ST_AUTO_LOOP);
  assign restart = (state_d != state_q);

  always_comb begin
    loop_flag_d = 1'b0;
    case (state_d)
      ST_MAN_UP, ST_MAN_DOWN: begin
        loop_flag_d = pat_held && !restart;
      end
      ST_AUTO_LOOP: begin
        loop_flag_d = 1'b1;
      end
      default: begin
        loop_flag_d = 1'b0;
      end
    endcase
  end

  assign remote_loop_d = (state_d == ST_AUTO_LOOP);

  always_ff @(posedge CLK) begin
    if (RST) begin
      state_q <= ST_OFF;
      loop_flag_q <= 1'b0;
      remote_loop_q <= 1'b0;
    end else begin
      state_q <= state_d;
      loop_flag_q <= loop_flag_d;
      remote_loop_q <= remote_loop_d;
    end
  end

  loop_pattern_watch #(
    .HOLD_CYCLES(HOLD_CYCLES)
  ) u_watch (
    .clk(CLK),
    .rst(RST),
    .bit_en(bit_en),
    .bit_val(bit_val),
    .want_down(want_down),
    .restart(restart),
    .present(pat_present),
    .held(pat_held)
  );

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0] wbyte_q;
  logic wstrb0_q;
  logic aw_full_q;
  logic w_full_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic aw_take;
  logic w_take;
  logic do_write;
  logic wr_hit;
  logic ar_take;
  logic rd_hit;
  logic [7:0] rd_byte;
  logic wr_ctrl;
  logic wr_istat;
  logic wr_mask;

  assign aw_take = S_AXI_AWVALID && awready_q;
  assign w_take = S_AXI_WVALID && wready_q;
  assign do_write = aw_full_q && w_full_q && !bvalid_q;
  assign wr_hit = awaddr_q inside {OFS_STATUS, OFS_CONTROL, OFS_IRQ_STATUS, OFS_IRQ_MASK};
  // every field lives in the low byte, so only lane 0 carries a write
  assign wr_ctrl = do_write && wstrb0_q && (awaddr_q == OFS_CONTROL);
  assign wr_istat = do_write && wstrb0_q && (awaddr_q == OFS_IRQ_STATUS);
  assign wr_mask = do_write && wstrb0_q && (awaddr_q == OFS_IRQ_MASK);
  assign ar_take = S_AXI_ARVALID && arready_q;

  always_ff @(posedge CLK) begin
    if (RST) begin
      awaddr_q <= '0;
      aw_full_q <= 1'b0;
      awready_q <= 1'b1;
    end else if (aw_take) begin
      awaddr_q <= S_AXI_AWADDR;
      aw_full_q <= 1'b1;
      awready_q <= 1'b0;
    end else if (bvalid_q && S_AXI_BREADY) begin
      aw_full_q <= 1'b0;
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      wbyte_q <= RESET_BYTE;
      wstrb0_q <= 1'b0;
      w_full_q <= 1'b0;
      wready_q <= 1'b1;
    end else if (w_take) begin
      wbyte_q <= S_AXI_WDATA[7:0];
      wstrb0_q <= S_AXI_WSTRB[0];
      w_full_q <= 1'b1;
      wready_q <= 1'b0;
    end else if (bvalid_q && S_AXI_BREADY) begin
      w_full_q <= 1'b0;
      wready_q <= 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers and interrupt
  logic [7:0] irq_stat_q;
  logic [7:0] irq_stat_d;
  logic [7:0] irq_mask_q;
  logic [7:0] irq_set;
  logic [7:0] status_byte;

  assign irq_set[BIT_FIFO_LIMIT] = (fifo_flag_d != fifo_flag_q);
  assign irq_set[BIT_LOOP_CODE] = (loop_flag_d != loop_flag_q);
  assign irq_set[7:6] = '0;
  assign irq_set[4] = 1'b0;
  assign irq_set[2:0] = '0;
  // a change in the same cycle as the clearing write stays pending
  assign irq_stat_d = (irq_stat_q & ~(wr_istat ? wbyte_q : RESET_BYTE)) | irq_set;

  always_ff @(posedge CLK) begin
    if (RST) begin
      mode_q <= MODE_OFF;
      irq_mask_q <= RESET_BYTE;
      irq_stat_q <= RESET_BYTE;
      IRQ <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        mode_q <= wbyte_q[BIT_MODE_HI:BIT_MODE_LO];
      end
      if (wr_mask) begin
        irq_mask_q <= wbyte_q & IRQ_BITS_MASK;
      end
      irq_stat_q <= irq_stat_d;
      IRQ <= |(irq_stat_d & irq_mask_q);
    end
  end

  always_comb begin
    status_byte = RESET_BYTE;
    status_byte[BIT_FIFO_LIMIT] = fifo_flag_q;
    status_byte[BIT_UNUSED] = 1'b0;
    status_byte[BIT_LOOP_CODE] = loop_flag_q;
    status_byte[BIT_REMOTE_LOOP] = remote_loop_q;
  end

  assign rd_hit = S_AXI_ARADDR inside {OFS_STATUS, OFS_CONTROL, OFS_IRQ_STATUS, OFS_IRQ_MASK};
  assign rd_byte = (S_AXI_ARADDR == OFS_STATUS) ? status_byte :
                   (S_AXI_ARADDR == OFS_CONTROL) ? {6'h00, mode_q} :
                   (S_AXI_ARADDR == OFS_IRQ_STATUS) ? irq_stat_q :
                   (S_AXI_ARADDR == OFS_IRQ_MASK) ? irq_mask_q : RESET_BYTE;

  always_ff @(posedge CLK) begin
    if (RST) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
    end else if (ar_take) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      rdata_q <= {24'h000000, rd_byte};
    end else if (rvalid_q && S_AXI_RREADY) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end
  end

  assign S_AXI_AWREADY = awready_q;
  assign S_AXI_WREADY = wready_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_ARREADY = arready_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RRESP = rresp_q;
  assign S_AXI_RDATA = rdata_q;
  assign REMOTE_LOOPBACK = remote_loop_q;

endmodule : loop_code_status
`default_nettype wire

// ---- dv/line_source.sv ----
// far-end line source: repeats a loop code or sends all ones
`timescale 1ns/10ps
`default_nettype none
module line_source (
  input wire logic clk,
  input wire logic [1:0] sel,
  output logic rx_data,
  output logic rx_strobe
);
  logic [2:0] ph_q = 3'h0;
  logic [3:0] idx_q = 4'h0;
  // data moves at phase 0, strobe at phase 3: stable well around the strobe edge
  always @(posedge clk) begin
    ph_q <= ph_q + 3'h1;
    rx_strobe <= (ph_q == 3'h3);
    if (ph_q == 3'h0) begin
      // 15 bits hold whole periods of both codes, so no seam in the stream
      idx_q <= (idx_q == 4'he) ? 4'h0 : idx_q + 4'h1;
      rx_data <= (sel == 2'h1) ? (idx_q % 5 == 4) : (sel == 2'h2) ? (idx_q % 3 == 2) : 1'b1;
    end
  end
endmodule : line_source
`default_nettype wire

// ---- dv/loop_code_props.sv ----
// port assertions of the loop-code status block
`timescale 1ns/10ps
`default_nettype none
module loop_code_props
  import loop_code_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = HOLD_CYCLES_DEF
) (
  input wire logic CLK,
  input wire logic RST,
  input wire loop_code_pkg::ja_ptr_s JA_PTRS,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic [loop_code_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic REMOTE_LOOPBACK
);
  import loop_code_pkg::*;
  logic [ADDR_W-1:0] rd_addr_q;
  logic [JA_PTR_W-1:0] fwd;
  logic [JA_PTR_W-1:0] bwd;
  logic near;
  logic mapped;
  assign fwd = JA_PTRS.wr - JA_PTRS.rd;
  assign bwd = JA_PTRS.rd - JA_PTRS.wr;
  assign near = (fwd <= JA_NEAR_LIMIT) || (bwd <= JA_NEAR_LIMIT);
  assign mapped = rd_addr_q inside {OFS_STATUS, OFS_CONTROL, OFS_IRQ_STATUS, OFS_IRQ_MASK};
  always_ff @(posedge CLK) begin
    if (S_AXI_ARVALID && S_AXI_ARREADY) rd_addr_q <= S_AXI_ARADDR;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////////////////
  a_unused_zero: assert property (
    $rose(S_AXI_RVALID) && rd_addr_q == OFS_STATUS |-> !S_AXI_RDATA[BIT_UNUSED])
    else $error("unused status bit read as one");
  // pointers held still for three cycles so the registered flag has settled
  a_fifo_flag: assert property (
    $rose(S_AXI_RVALID) && rd_addr_q == OFS_STATUS && $past(JA_PTRS, 1) == JA_PTRS
    && $past(JA_PTRS, 2) == JA_PTRS && $past(JA_PTRS, 3) == JA_PTRS |-> S_AXI_RDATA[BIT_FIFO_LIMIT] == near)
    else $error("fifo limit flag disagrees with pointers");
  a_loop_in_remote: assert property (
    $rose(S_AXI_RVALID) && rd_addr_q == OFS_STATUS && $past(REMOTE_LOOPBACK, 1) && $past(REMOTE_LOOPBACK, 2)
    |-> S_AXI_RDATA[BIT_LOOP_CODE] && S_AXI_RDATA[BIT_REMOTE_LOOP])
    else $error("loop flag low during remote loop-back");
  a_read_resp: assert property (
    $rose(S_AXI_RVALID) |-> S_AXI_RRESP == (mapped ? RESP_OKAY : RESP_SLVERR))
    else $error("read response code wrong");
  a_read_prompt: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer late");
  a_write_prompt: assert property (
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
    else $error("write answer late");
  a_read_holds: assert property (
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA) && $stable(S_AXI_RRESP))
    else $error("read answer dropped early");
  a_write_holds: assert property (
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write answer dropped early");
endmodule : loop_code_props
bind loop_code_status loop_code_props #(.HOLD_CYCLES(HOLD_CYCLES)) u_props (.*);
`default_nettype wire

// ---- dv/loop_code_status_tb.sv ----
// self-checking bench for the loop-code status block
`timescale 1ns/10ps
`default_nettype none
module loop_code_status_tb;
  import loop_code_pkg::*;
  // short hold so a five-second qualification fits a short run
  localparam int unsigned HOLD = 50;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic RX_DATA;
  logic RX_STROBE;
  ja_ptr_s JA_PTRS = '{wr: 5'h10, rd: 5'h00};
  logic [ADDR_W-1:0] S_AXI_AWADDR = '0;
  logic [ADDR_W-1:0] S_AXI_ARADDR = '0;
  logic [31:0] S_AXI_WDATA = '0;
  logic [31:0] S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB = 4'hf;
  logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0, S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, IRQ, REMOTE_LOOPBACK;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rsp;
  logic [1:0] line_sel = 2'h1;
  logic [31:0] rdat;
  logic [10:0] fl [4] = '{{5'h03, 5'h00, 1'b1}, {5'h04, 5'h00, 1'b0}, {5'h1d, 5'h00, 1'b1}, {5'h1c, 5'h00, 1'b0}};
  logic [3:0] ofs [4] = '{OFS_STATUS, OFS_CONTROL, OFS_IRQ_STATUS, OFS_IRQ_MASK};
  int err_count = 0;
  int n_checks = 0;
  always #2.5 CLK = ~CLK;
  loop_code_status #(.HOLD_CYCLES(HOLD)) u_dut (.*);
  line_source u_line (.clk(CLK), .sel(line_sel), .rx_data(RX_DATA), .rx_strobe(RX_STROBE));
  ////////////////////////////////////////////////////////////
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task axi_wr(input logic [3:0] a, input logic [7:0] d, output logic [1:0] r);
    int n;
    @(posedge CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= {24'h0, d};
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      n++;
    end while (S_AXI_BVALID !== 1'b1 && n < 40);
    chk("write answer", 1, S_AXI_BVALID);
    r = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
  endtask : axi_wr
  task axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      n++;
    end while (S_AXI_RVALID !== 1'b1 && n < 40);
    chk("read answer", 1, S_AXI_RVALID);
    d = S_AXI_RDATA;
    r = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
  endtask : axi_rd
  task wok(input logic [3:0] a, input logic [7:0] d);
    axi_wr(a, d, rsp);
    chk("write resp", RESP_OKAY, rsp);
  endtask : wok
  task rchk(input logic [3:0] a, input logic [7:0] e, input string what);
    axi_rd(a, rdat, rsp);
    chk(what, {24'h0, e}, rdat);
    chk("read resp", RESP_OKAY, rsp);
  endtask : rchk
  task wait_remote(input logic e);
    int n;
    n = 0;
    while (REMOTE_LOOPBACK !== e && n < 300) begin
      @(posedge CLK);
      n++;
    end
    chk("remote loop-back", e, REMOTE_LOOPBACK);
  endtask : wait_remote
  task print_verdict;
    $display("checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge CLK);
    RST <= 1'b0;
    foreach (ofs[i]) rchk(ofs[i], 8'h00, "reset value");
    axi_rd(4'h2, rdat, rsp);
    chk("unmapped read resp", RESP_SLVERR, rsp);
    chk("unmapped read data", 0, rdat);
    axi_wr(4'h6, 8'hff, rsp);
    chk("unmapped write", RESP_SLVERR, rsp);
    wok(OFS_STATUS, 8'hff);
    // loop-up code has been on the line all along while detection is off
    repeat (150) @(posedge CLK);
    rchk(OFS_STATUS, 8'h00, "status, mode off");
    chk("remote, mode off", 0, REMOTE_LOOPBACK);
    $display("test reset and map done");
    wok(OFS_IRQ_MASK, 8'h20);
    foreach (fl[i]) begin
      JA_PTRS <= '{wr: fl[i][10:6], rd: fl[i][5:1]};
      repeat (4) @(posedge CLK);
      rchk(OFS_STATUS, {2'h0, fl[i][0], 5'h00}, "fifo flag");
      rchk(OFS_IRQ_STATUS, 8'h20, "fifo event");
      chk("irq", 1, IRQ);
      wok(OFS_IRQ_STATUS, 8'h20);
    end
    repeat (2) @(posedge CLK);
    chk("irq cleared", 0, IRQ);
    wok(OFS_IRQ_MASK, 8'h00);
    JA_PTRS <= '{wr: 5'h03, rd: 5'h00};
    repeat (4) @(posedge CLK);
    rchk(OFS_IRQ_STATUS, 8'h20, "masked fifo event");
    chk("irq masked", 0, IRQ);
    JA_PTRS <= '{wr: 5'h10, rd: 5'h00};
    repeat (4) @(posedge CLK);
    wok(OFS_IRQ_STATUS, 8'h20);
    $display("test fifo limit done");
    wok(OFS_IRQ_MASK, 8'h08);
    wok(OFS_CONTROL, {6'h0, MODE_MAN_UP});
    rchk(OFS_STATUS, 8'h00, "up flag before hold");
    repeat (100) @(posedge CLK);
    rchk(OFS_STATUS, 8'h08, "up flag after hold");
    chk("irq on rise", 1, IRQ);
    wok(OFS_IRQ_STATUS, 8'h08);
    line_sel <= 2'h0;
    repeat (30) @(posedge CLK);
    rchk(OFS_STATUS, 8'h00, "up flag after break");
    rchk(OFS_IRQ_STATUS, 8'h08, "up fall event");
    wok(OFS_IRQ_STATUS, 8'h08);
    $display("test manual up done");
    wok(OFS_CONTROL, {6'h0, MODE_MAN_DOWN});
    line_sel <= 2'h2;
    repeat (30) @(posedge CLK);
    rchk(OFS_STATUS, 8'h00, "down flag before hold");
    repeat (100) @(posedge CLK);
    rchk(OFS_STATUS, 8'h08, "down flag after hold");
    line_sel <= 2'h0;
    repeat (30) @(posedge CLK);
    rchk(OFS_STATUS, 8'h00, "down flag after break");
    rchk(OFS_IRQ_STATUS, 8'h08, "down events");
    wok(OFS_IRQ_STATUS, 8'h08);
    line_sel <= 2'h2;
    repeat (130) @(posedge CLK);
    $display("test manual down done");
    wok(OFS_CONTROL, {6'h0, MODE_AUTO});
    rchk(OFS_STATUS, 8'h00, "auto entry clears flag");
    line_sel <= 2'h1;
    wait_remote(1'b1);
    repeat (4) @(posedge CLK);
    rchk(OFS_STATUS, 8'h0c, "auto loop set");
    repeat (100) @(posedge CLK);
    chk("remote under loop-up", 1, REMOTE_LOOPBACK);
    line_sel <= 2'h0;
    repeat (300) @(posedge CLK);
    rchk(OFS_STATUS, 8'h0c, "auto loop held");
    wok(OFS_IRQ_STATUS, 8'h08);
    line_sel <= 2'h2;
    wait_remote(1'b0);
    repeat (4) @(posedge CLK);
    rchk(OFS_STATUS, 8'h00, "auto loop ended");
    rchk(OFS_IRQ_STATUS, 8'h08, "auto end event");
    chk("irq on end", 1, IRQ);
    $display("test automatic done");
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge CLK);
    err_count++;
    print_verdict();
  end
endmodule : loop_code_status_tb
`default_nettype wire
